/* hw/wake_pkg.sv */
// Purpose: Constants for the GPIO wake-up event counter.
// Assumes: 100 MHz clock, APB slave with 32-bit data.
// Notes:   Register offsets are byte addresses.
// Contract
// - Software selects per pin which inputs may produce events.
// - With all pins selected, an active edge on any pin can wake the system unless another pin is already held active.
// - Each pin has a polarity bit choosing its active edge.
// - Polarity 0 makes a rising edge raise key hit.
// - A key hit loads the debounce counter from the control field.
// - The debounce counter decrements once per millisecond tick.
// - At zero with key hit still active, the event count increments.
// - After an active edge the opposite edge must come before idle.
// - Count equal to a nonzero target clears count; interrupt only if enabled or the match mask bit is set.
// - Any write to interrupt clear drops the pending interrupt, unless an enabled match sets it in the same cycle.
// - Any write to count clear returns the event count to zero.
// - The event count is readable at any time without disturbing it.
// - Debounce covers every whole millisecond from 0 to 63.
`default_nettype none

package wake_pkg;
   localparam int          PIN_COUNT      = 32;
   localparam int          COUNT_W        = 8;
   localparam int          DEB_W          = 6;
   localparam logic [11:0] OFF_SELECT     = 12'h000;
   localparam logic [11:0] OFF_POLARITY   = 12'h004;
   localparam logic [11:0] OFF_CONTROL    = 12'h008;
   localparam logic [11:0] OFF_TARGET     = 12'h00C;
   localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h010;
   localparam logic [11:0] OFF_CNT_CLEAR  = 12'h014;
   localparam logic [11:0] OFF_COUNT      = 12'h018;
   localparam logic [11:0] OFF_STATUS     = 12'h01C;
   localparam logic [11:0] OFF_MASK       = 12'h020;
   localparam int          CTL_DEB_LSB    = 0;
   localparam int          CTL_IRQ_EN_BIT = 6;
   localparam int          ST_EVENT_BIT   = 0;
   localparam int          ST_MATCH_BIT   = 1;
   localparam int          ST_W           = 2;
   localparam int          TICK_MS        = 1;
   localparam int          CLK_MHZ        = 100;
   localparam int          TICK_CYCLES    = TICK_MS * CLK_MHZ * 1000;
   localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;
endpackage : wake_pkg

`default_nettype wire

/* hw/ms_tick_gen.sv */
// Purpose: Millisecond tick pulse from the system clock.
// Assumes: Synchronous active-low reset.
// Notes:   One-cycle pulse every tick_cycles clocks.
`default_nettype none

module ms_tick_gen #(
   parameter int tick_cycles = wake_pkg::TICK_CYCLES
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic resetn,
   // Tick output.
   output logic      tick
);
   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } st_t;

   st_t st_r;
   st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt == 32'(tick_cycles - 1))
      begin
         st_nxt.cnt = 32'h0000_0000;
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;
endmodule : ms_tick_gen

`default_nettype wire

/* hw/wake_counter.sv */
// Purpose: GPIO wake-up event counter with debounce, compare and interrupt.
// Assumes: Pins synchronous to clk; APB3 slave, zero wait states.
// Notes:   One shared debounce state machine serves all selected pins.
`default_nettype none

module wake_counter #(
   parameter int tick_cycles = wake_pkg::TICK_CYCLES
) (
   // Clock and reset.
   input  wire logic                               clk,
   input  wire logic                               resetn,
   // APB slave.
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [11:0]                        paddr,
   input  wire logic [31:0]                        pwdata,
   output logic [31:0]                             prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   // Pins and interrupt.
   input  wire logic [wake_pkg::PIN_COUNT-1:0]     gpio_in,
   output logic                                    wake_irq
);
   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_DEB   = 3'b010,
      S_WAIT  = 3'b100
   } fsm_t;

   typedef struct packed {
      logic [wake_pkg::PIN_COUNT-1:0] pin_event_select;
      logic [wake_pkg::PIN_COUNT-1:0] pin_edge_polarity;
      logic [wake_pkg::DEB_W-1:0]     debounce_ms_setting;
      logic                           irq_enable;
      logic [wake_pkg::COUNT_W-1:0]   event_target_count;
      logic [wake_pkg::COUNT_W-1:0]   event_count_value;
      logic [wake_pkg::ST_W-1:0]      status;
      logic [wake_pkg::ST_W-1:0]      mask;
      logic                           wake_pending;
      logic [wake_pkg::PIN_COUNT-1:0] act_prev;
      logic [wake_pkg::DEB_W-1:0]     deb_cnt;
      fsm_t                           fsm;
      logic [31:0]                    rdata;
   } st_t;

   st_t st_r;
   st_t st_nxt;
   logic tick;
   logic [wake_pkg::PIN_COUNT-1:0] active;
   logic key_hit;
   logic key_rise;
   logic wr_en;
   logic rd_en;
   logic ev_seen;

   ms_tick_gen #(
      .tick_cycles (tick_cycles)
   ) u_tick (
      .clk    (clk),
      .resetn (resetn),
      .tick   (tick)
   );

   // Per pin active level: polarity 1 inverts, so a falling pin edge is active.
   genvar gi;
   generate
      for (gi = 0; gi < wake_pkg::PIN_COUNT; gi++)
      begin : g_pin
         assign active[gi] = st_r.pin_event_select[gi] &
                             (gpio_in[gi] ^ st_r.pin_edge_polarity[gi]);
      end
   endgenerate

   assign key_hit  = |active;
   assign key_rise = |(active & ~st_r.act_prev);
   assign wr_en    = psel & penable & pwrite;
   assign rd_en    = psel & ~penable & ~pwrite;

   always_comb
   begin
      logic [wake_pkg::ST_W-1:0] ev;
      logic                      clr_cnt;
      ev = '0;
      clr_cnt = 1'b0;
      st_nxt = st_r;
      st_nxt.act_prev = active;
      unique case (st_r.fsm)
         S_IDLE:
         begin
            if (key_rise)
            begin
               st_nxt.deb_cnt = st_r.debounce_ms_setting;
               st_nxt.fsm = S_DEB;
            end
         end
         S_DEB:
         begin
            if (!key_hit)
            begin
               st_nxt.fsm = S_IDLE;
            end
            else if (tick)
            begin
               if (st_r.deb_cnt == '0)
               begin
                  st_nxt.event_count_value = st_r.event_count_value + 1'b1;
                  ev[wake_pkg::ST_EVENT_BIT] = 1'b1;
                  st_nxt.fsm = S_WAIT;
               end
               else
               begin
                  st_nxt.deb_cnt = st_r.deb_cnt - 1'b1;
               end
            end
         end
         S_WAIT:
         begin
            if (!key_hit)
            begin
               st_nxt.fsm = S_IDLE;
            end
         end
      endcase
      if (st_r.event_count_value == st_r.event_target_count &&
          st_r.event_target_count != '0)
      begin
         clr_cnt = 1'b1;
         ev[wake_pkg::ST_MATCH_BIT] = 1'b1;
      end
      if (wr_en)
      begin
         unique case (paddr)
            wake_pkg::OFF_SELECT:    st_nxt.pin_event_select = pwdata;
            wake_pkg::OFF_POLARITY:  st_nxt.pin_edge_polarity = pwdata;
            wake_pkg::OFF_CONTROL:
            begin
               st_nxt.debounce_ms_setting =
                  pwdata[wake_pkg::CTL_DEB_LSB +: wake_pkg::DEB_W];
               st_nxt.irq_enable = pwdata[wake_pkg::CTL_IRQ_EN_BIT];
            end
            wake_pkg::OFF_TARGET:
               st_nxt.event_target_count = pwdata[wake_pkg::COUNT_W-1:0];
            wake_pkg::OFF_IRQ_CLEAR: st_nxt.wake_pending = 1'b0;
            wake_pkg::OFF_CNT_CLEAR: clr_cnt = 1'b1;
            wake_pkg::OFF_STATUS:
               st_nxt.status = st_r.status & ~pwdata[wake_pkg::ST_W-1:0];
            wake_pkg::OFF_MASK:      st_nxt.mask = pwdata[wake_pkg::ST_W-1:0];
            default:                 ;
         endcase
      end
      if (clr_cnt)
      begin
         st_nxt.event_count_value = '0;
      end
      // Hardware set wins over a same-cycle software clear.
      if (ev[wake_pkg::ST_MATCH_BIT] && st_r.irq_enable)
      begin
         st_nxt.wake_pending = 1'b1;
      end
      st_nxt.status = st_nxt.status | ev;
      if (rd_en)
      begin
         unique case (paddr)
            wake_pkg::OFF_SELECT:   st_nxt.rdata = st_r.pin_event_select;
            wake_pkg::OFF_POLARITY: st_nxt.rdata = st_r.pin_edge_polarity;
            wake_pkg::OFF_CONTROL:
               st_nxt.rdata = {25'h0, st_r.irq_enable, st_r.debounce_ms_setting};
            wake_pkg::OFF_TARGET:   st_nxt.rdata = {24'h0, st_r.event_target_count};
            wake_pkg::OFF_COUNT:    st_nxt.rdata = {24'h0, st_r.event_count_value};
            wake_pkg::OFF_STATUS:   st_nxt.rdata = {30'h0, st_r.status};
            wake_pkg::OFF_MASK:     st_nxt.rdata = {30'h0, st_r.mask};
            default:                st_nxt.rdata = wake_pkg::RESET_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         st_r <= '0;
         st_r.fsm <= S_IDLE;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign prdata   = st_r.rdata;
   assign pready   = 1'b1;
   assign pslverr  = 1'b0;
   assign wake_irq = st_r.wake_pending | (|(st_r.status & st_r.mask));

   a_count_step: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_DEB && key_hit && tick && st_r.deb_cnt == '0 && !wr_en &&
       st_r.event_count_value != st_r.event_target_count)
      |=> st_r.event_count_value == $past(st_r.event_count_value) + 1'b1)
      else $error("event count did not step");
   a_deb_load: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_IDLE && key_rise) |=> st_r.deb_cnt == $past(st_r.debounce_ms_setting))
      else $error("debounce not loaded");
   a_deb_tick: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_DEB && !tick) |=> st_r.deb_cnt == $past(st_r.deb_cnt))
      else $error("debounce moved without tick");
   a_wait_hold: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_WAIT && key_hit) |=> st_r.fsm == S_WAIT)
      else $error("left wait without reverse edge");
   a_match_irq: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.event_count_value == st_r.event_target_count && st_r.event_target_count != '0
       && st_r.irq_enable) |=> wake_irq && st_r.event_count_value == '0)
      else $error("match did not raise interrupt");
   a_irq_clear: assert property (@(posedge clk) disable iff (!resetn)
      (wr_en && paddr == wake_pkg::OFF_IRQ_CLEAR && st_r.event_count_value !=
       st_r.event_target_count) |=> !st_r.wake_pending)
      else $error("interrupt clear ignored");
   a_cnt_clear: assert property (@(posedge clk) disable iff (!resetn)
      (wr_en && paddr == wake_pkg::OFF_CNT_CLEAR) |=> st_r.event_count_value == '0)
      else $error("count clear ignored");
   a_unsel_quiet: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.pin_event_select == '0) |-> !key_hit)
      else $error("unselected pin made event");

   // These watch the debounce walk one state at a time, then count, interrupt, tick and reads.
   a_deb_step: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_DEB && key_hit && tick && st_r.deb_cnt != '0)
      |=> st_r.deb_cnt == $past(st_r.deb_cnt) - 1'b1)
      else $error("debounce did not step down on tick");

   a_deb_abort: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_DEB && !key_hit) |=> st_r.fsm == S_IDLE)
      else $error("debounce kept without key hit");

   a_wait_exit: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_WAIT && !key_hit) |=> st_r.fsm == S_IDLE)
      else $error("wait did not return to idle");

   a_idle_arm: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_IDLE && key_rise) |=> st_r.fsm == S_DEB)
      else $error("active edge did not start debounce");

   a_idle_hold: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_IDLE && !key_rise) |=> st_r.fsm == S_IDLE)
      else $error("idle left without active edge");

   a_wait_nocount: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_WAIT) |=> st_r.fsm != S_DEB)
      else $error("wait went straight to debounce");

   a_count_still: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm != S_DEB && !wr_en &&
       st_r.event_count_value != st_r.event_target_count)
      |=> $stable(st_r.event_count_value))
      else $error("count moved outside debounce");

   a_status_set: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.fsm == S_DEB && key_hit && tick && st_r.deb_cnt == '0)
      |=> st_r.status[wake_pkg::ST_EVENT_BIT])
      else $error("counted event not flagged");

   a_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
      (!st_r.irq_enable && !st_r.wake_pending) |=> !st_r.wake_pending)
      else $error("interrupt raised while disabled");

   a_pend_set: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.event_count_value == st_r.event_target_count &&
       st_r.event_target_count != '0 && st_r.irq_enable) |=> st_r.wake_pending)
      else $error("match did not set pending");

   a_match_clear: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.event_count_value == st_r.event_target_count &&
       st_r.event_target_count != '0) |=> st_r.event_count_value == '0)
      else $error("match did not clear count");

   a_pend_hold: assert property (@(posedge clk) disable iff (!resetn)
      (st_r.wake_pending && !(wr_en && paddr == wake_pkg::OFF_IRQ_CLEAR))
      |=> st_r.wake_pending)
      else $error("pending dropped without clear");

   a_tick_pulse: assert property (@(posedge clk) disable iff (!resetn)
      tick |=> !tick)
      else $error("tick wider than one cycle");

   a_rdata_count: assert property (@(posedge clk) disable iff (!resetn)
      (rd_en && paddr == wake_pkg::OFF_COUNT)
      |=> prdata == {24'h0, $past(st_r.event_count_value)})
      else $error("count read wrong");

   a_ctl_read: assert property (@(posedge clk) disable iff (!resetn)
      (rd_en && paddr == wake_pkg::OFF_CONTROL)
      |=> prdata[wake_pkg::DEB_W-1:0] == $past(st_r.debounce_ms_setting))
      else $error("debounce setting read wrong");

   a_tgt_read: assert property (@(posedge clk) disable iff (!resetn)
      (rd_en && paddr == wake_pkg::OFF_TARGET)
      |=> prdata == {24'h0, $past(st_r.event_target_count)})
      else $error("target read wrong");

   a_sel_read: assert property (@(posedge clk) disable iff (!resetn)
      (rd_en && paddr == wake_pkg::OFF_SELECT)
      |=> prdata == $past(st_r.pin_event_select))
      else $error("select read wrong");

   a_pol_read: assert property (@(posedge clk) disable iff (!resetn)
      (rd_en && paddr == wake_pkg::OFF_POLARITY)
      |=> prdata == $past(st_r.pin_edge_polarity))
      else $error("polarity read wrong");

   // Each pin is gated by its own select and polarity bits.
   generate
      for (gi = 0; gi < wake_pkg::PIN_COUNT; gi++)
      begin : g_pin_chk
         a_pin_gate: assert property (@(posedge clk) disable iff (!resetn)
            !st_r.pin_event_select[gi] |-> !active[gi])
            else $error("unselected pin active");
         a_pin_pol: assert property (@(posedge clk) disable iff (!resetn)
            (st_r.pin_event_select[gi] && (gpio_in[gi] != st_r.pin_edge_polarity[gi]))
            |-> active[gi])
            else $error("pin polarity not applied");
      end
   endgenerate

   c_event: cover property (@(posedge clk) ev_seen);
   c_match: cover property (@(posedge clk) st_r.wake_pending);
   c_rearm: cover property (@(posedge clk) st_r.fsm == S_WAIT ##[1:100] st_r.fsm == S_IDLE);
   c_debounce: cover property (@(posedge clk) st_r.fsm == S_DEB);
   c_cnt_clear: cover property (@(posedge clk) wr_en && paddr == wake_pkg::OFF_CNT_CLEAR);

   assign ev_seen = st_r.status[wake_pkg::ST_EVENT_BIT];
endmodule : wake_counter

`default_nettype wire

/* testbench/pin_model.sv */
// Purpose: Pin-side model driving the wake-up input levels.
// Assumes: Pins are synchronous to clk.
// Notes:   A requested level lands on the pins one edge later.
`default_nettype none

module pin_model (
   // Clock and request.
   input  wire logic        clk,
   input  wire logic [31:0] want,
   // Pin levels.
   output logic      [31:0] gpio_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial gpio_in = 32'h0000_0000;
   always @(posedge clk)
   begin
      gpio_in <= want;
   end
endmodule : pin_model

`default_nettype wire

/* testbench/wake_counter_tb_top.sv */
// Purpose: Self-checking bench for the wake-up event counter.
// Assumes: Tick every 10 clocks, zero-wait APB slave.
// Notes:   Reads queue an expected word; a monitor compares it.
`default_nettype none

module wake_counter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, resetn, psel, penable, pwrite, pready, pslverr, wake_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, gpio_in, want;
   logic [31:0] exp_q[$];
   int          bad_count, total_checks, seed;

   wake_counter #(.tick_cycles(10)) dut_u (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
      .wake_irq(wake_irq));
   pin_model pins_u (.clk(clk), .want(want), .gpio_in(gpio_in));

   always #5 clk = ~clk;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         bad_count++;
         stop_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      xfer(1'b0, a, 32'h0000_0000);
   endtask : rd

   task automatic ticks(input int n);
      repeat (n * 10 + 3) @(posedge clk);
   endtask : ticks

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge clk);
      check({31'h0, wake_irq}, {31'h0, exp});
   endtask : irq_is

   // Read data is taken at the edge that ends the access phase, before that edge's updates land.
   always @(posedge clk)
   begin
      if (psel && penable && pready && !pwrite)
      begin
         check(prdata, exp_q.pop_front());
         check({31'h0, pslverr}, 32'h0000_0000);
      end
   end

   initial
   begin
      seed = 47;
      clk = 1'b0;
      resetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      want = 32'h0000_0008;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0000);
      rd(12'h040, 32'h0000_0000);
      irq_is(1'b0);
      $display("test reset done");
      xfer(1'b1, wake_pkg::OFF_POLARITY, 32'h0000_0008);
      xfer(1'b1, wake_pkg::OFF_SELECT, 32'h0000_0009);
      xfer(1'b1, wake_pkg::OFF_CONTROL, 32'h0000_0042);
      xfer(1'b1, wake_pkg::OFF_TARGET, 32'h0000_0003);
      want <= 32'h0000_0028;
      ticks(5);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0000);
      want <= 32'h0000_0009;
      ticks(5);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0001);
      want <= 32'h0000_0001;
      ticks(5);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0001);
      want <= 32'h0000_0008;
      ticks(2);
      want <= 32'h0000_0000;
      ticks(5);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0002);
      want <= 32'h0000_0008;
      ticks(2);
      want <= 32'h0000_0009;
      ticks(5);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0000);
      irq_is(1'b1);
      rd(wake_pkg::OFF_STATUS, 32'h0000_0003);
      xfer(1'b1, wake_pkg::OFF_IRQ_CLEAR, $random(seed));
      irq_is(1'b0);
      xfer(1'b1, wake_pkg::OFF_STATUS, 32'h0000_0003);
      rd(wake_pkg::OFF_STATUS, 32'h0000_0000);
      $display("test edges done");
      want <= 32'h0000_0008;
      ticks(2);
      want <= 32'h0000_0009;
      repeat (3) @(posedge clk);
      want <= 32'h0000_0008;
      ticks(5);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0000);
      want <= 32'h0000_0009;
      ticks(5);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0001);
      xfer(1'b1, wake_pkg::OFF_CNT_CLEAR, $random(seed));
      rd(wake_pkg::OFF_COUNT, 32'h0000_0000);
      $display("test clears done");
      want <= 32'h0000_0000;
      ticks(2);
      xfer(1'b1, wake_pkg::OFF_POLARITY, 32'h0000_0000);
      xfer(1'b1, wake_pkg::OFF_SELECT, 32'hFFFF_FFFF);
      xfer(1'b1, wake_pkg::OFF_CONTROL, 32'h0000_0000);
      xfer(1'b1, wake_pkg::OFF_TARGET, 32'h0000_0001);
      xfer(1'b1, wake_pkg::OFF_STATUS, 32'h0000_0003);
      want <= 32'h0000_0001 << ($random(seed) & 31);
      ticks(3);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0000);
      irq_is(1'b0);
      rd(wake_pkg::OFF_STATUS, 32'h0000_0003);
      xfer(1'b1, wake_pkg::OFF_MASK, 32'h0000_0001);
      irq_is(1'b1);
      xfer(1'b1, wake_pkg::OFF_STATUS, 32'h0000_0001);
      irq_is(1'b0);
      $display("test mask done");
      want <= 32'h0000_0000;
      xfer(1'b1, wake_pkg::OFF_MASK, 32'h0000_0000);
      xfer(1'b1, wake_pkg::OFF_TARGET, 32'h0000_0000);
      xfer(1'b1, wake_pkg::OFF_CONTROL, 32'h0000_003F);
      ticks(2);
      want <= 32'h0000_0010;
      ticks(62);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0000);
      ticks(3);
      rd(wake_pkg::OFF_COUNT, 32'h0000_0001);
      $display("test long debounce done");
      repeat (3) @(posedge clk);
      stop_test();
   end
endmodule : wake_counter_tb_top

`default_nettype wire
